// file: core/dbr_top.sv
// debug enclave read leaf: checks, page map lookup and result commit
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
`include "dbr_regs.svh"

module dbr_top
    import dbr_pkg::*;
(
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         reset_i,
    // register bus
    input  wire dbr_bus_t     bus_i,
    output logic [31:0]       rdata_o,
    // segment unit
    input  wire logic         seg_viol_i,
    input  wire logic         seg_unusable_i,
    // page map lookup
    output logic              pm_req_o,
    output logic [63:0]       pm_addr_o,
    input  wire logic         pm_ack_i,
    input  wire dbr_pm_resp_t pm_resp_i,
    // outcome to the processor
    output logic              done_o,
    output logic              gp_fault_o,
    output logic              pf_fault_o,
    output logic [63:0]       fault_addr_o,
    output logic              irq_o
);
    typedef struct packed {
        dbr_state_t  state;
        dbr_out_t    outcome;
        logic [63:0] addr;
        logic        long_mode;
        logic [31:0] leaf_err;
        logic [63:0] result;
        logic [63:0] stage;
        dbr_flags_t  flags;
        logic [1:0]  last_fault;
        logic [31:0] rdata;
    } dbr_core_t;

    dbr_core_t   core_ff;
    dbr_core_t   nxt_core;
    logic [63:0] fmt_result;
    logic [3:0]  irq_stat;
    logic [3:0]  irq_en;
    logic [3:0]  events;
    logic        ctrl_we;
    logic        start_req;
    logic        is_reg_tcs;

    // natural alignment depends on the transfer size of the mode
    function automatic logic dbr_misaligned(logic [63:0] a, logic lm);
        return lm ? (a[2:0] != 3'h0) : (a[1:0] != 2'h0);
    endfunction

    // regular and thread control pages hold real data
    function automatic logic dbr_is_data_page(logic [7:0] pt);
        return (pt == `DBR_REGULAR_PAGE_TYPE) || (pt == `DBR_THREAD_CONTROL_PAGE_TYPE);
    endfunction

    // enclave_control_structure pages and unknown codes fall outside the permitted set
    function automatic logic dbr_type_ok(logic [7:0] pt);
        return dbr_is_data_page(pt) || (pt == `DBR_VERSION_ARRAY_PAGE_TYPE) ||
               (pt == `DBR_SHADOW_STACK_FIRST_PAGE_TYPE) || (pt == `DBR_SHADOW_STACK_REST_PAGE_TYPE);
    endfunction

    // page map checks, strictly in order; permission bits are not consulted
    function automatic dbr_out_t dbr_decide(dbr_pm_resp_t r, logic [11:0] off);
        dbr_out_t o;
        o = DBR_OK;
        if (!r.in_epc) begin
            o = DBR_PF;
        end else if (r.conflict) begin
            o = DBR_GP;
        end else if (!r.valid) begin
            o = DBR_PF;
        end else if (!dbr_type_ok(r.ptype)) begin
            o = DBR_PF;
        end else if (r.pending || r.modified) begin
            o = DBR_NDBG;
        end else if ((r.ptype == `DBR_THREAD_CONTROL_PAGE_TYPE) && (off >= `DBR_TCS_LIMIT)) begin
            o = DBR_GP;
        end else if (dbr_is_data_page(r.ptype) && !r.owner_debug) begin
            o = DBR_GP;
        end
        return o;
    endfunction

    assign ctrl_we    = bus_i.we && (bus_i.addr == `DBR_OFF_CTRL);
    assign start_req  = ctrl_we && bus_i.wdata[`DBR_CTRL_START];
    assign is_reg_tcs = dbr_is_data_page(pm_resp_i.ptype);

    // result shaping kept apart so the mode split stays readable
    dbr_fmt u_fmt (
        .long_i       (core_ff.long_mode),
        .reg_or_tcs_i (is_reg_tcs),
        .mem_i        (pm_resp_i.data),
        .prev_i       (core_ff.result),
        .result_o     (fmt_result)
    );

    // one event per finished leaf, taken from the stored outcome
    assign events = (core_ff.state == DBR_DONE) ? core_ff.outcome : 4'h0;

    dbr_irq u_irq (
        .clk_i    (clk_i),
        .reset_i  (reset_i),
        .event_i  (events),
        .clr_we_i (bus_i.we && (bus_i.addr == `DBR_OFF_IRQ_CLR)),
        .en_we_i  (bus_i.we && (bus_i.addr == `DBR_OFF_IRQ_EN)),
        .wdata_i  (bus_i.wdata[3:0]),
        .stat_o   (irq_stat),
        .en_o     (irq_en),
        .irq_o    (irq_o)
    );

    // next state of the whole block except the interrupt state kept in dbr_irq
    always_comb begin
        nxt_core = core_ff;
        // operand writes are refused while a leaf is in flight
        if (bus_i.we && (core_ff.state == DBR_IDLE)) begin
            unique case (bus_i.addr)
                `DBR_OFF_LEAF: begin
                    nxt_core.leaf_err = bus_i.wdata;
                end
                `DBR_OFF_ADDR_LO: begin
                    nxt_core.addr[31:0] = bus_i.wdata;
                end
                `DBR_OFF_ADDR_HI: begin
                    nxt_core.addr[63:32] = bus_i.wdata;
                end
                `DBR_OFF_CTRL: begin
                    // mode comes from the long bit of the control write, not the processor state
                    nxt_core.long_mode = bus_i.wdata[`DBR_CTRL_LONG];
                end
                default: begin
                end
            endcase
        end
        unique case (core_ff.state)
            DBR_IDLE: begin
                if (start_req && (core_ff.leaf_err == `DBR_LEAF_READ)) begin
                    nxt_core.state = DBR_DONE;
                    if (seg_viol_i || seg_unusable_i) begin
                        nxt_core.outcome = DBR_GP;
                    end else if (dbr_misaligned(nxt_core.addr,
                                                nxt_core.long_mode)) begin
                        nxt_core.outcome = DBR_GP;
                    end else begin
                        nxt_core.state = DBR_WAIT;
                    end
                end
            end
            DBR_WAIT: begin
                if (pm_ack_i) begin
                    nxt_core.outcome = dbr_decide(pm_resp_i, core_ff.addr[11:0]);
                    nxt_core.stage   = fmt_result;
                    nxt_core.state   = DBR_DONE;
                end
            end
            DBR_DONE: begin
                nxt_core.state = DBR_IDLE;
                unique case (core_ff.outcome)
                    DBR_OK: begin
                        nxt_core.result   = core_ff.stage;
                        nxt_core.leaf_err = `DBR_RST_WORD;
                        nxt_core.flags    = '0;
                    end
                    DBR_NDBG: begin
                        // no data moves on this exit
                        nxt_core.leaf_err = `DBR_ERR_NOT_DEBUG;
                        nxt_core.flags    = '0;
                        nxt_core.flags.zf = 1'b1;
                    end
                    DBR_GP: begin
                        nxt_core.last_fault = 2'b01;
                    end
                    DBR_PF: begin
                        nxt_core.last_fault = 2'b10;
                    end
                    default: begin
                    end
                endcase
            end
            default: begin
                nxt_core.state = DBR_IDLE;
            end
        endcase
        // read data stand in the cycle after the strobe only
        nxt_core.rdata = `DBR_RST_WORD;
        if (bus_i.re) begin
            unique case (bus_i.addr)
                `DBR_OFF_LEAF:     nxt_core.rdata = core_ff.leaf_err;
                `DBR_OFF_ADDR_LO:  nxt_core.rdata = core_ff.addr[31:0];
                `DBR_OFF_ADDR_HI:  nxt_core.rdata = core_ff.addr[63:32];
                `DBR_OFF_CTRL:     nxt_core.rdata = {31'h0, core_ff.long_mode};
                `DBR_OFF_RES_LO:   nxt_core.rdata = core_ff.result[31:0];
                `DBR_OFF_RES_HI:   nxt_core.rdata = core_ff.result[63:32];
                `DBR_OFF_FLAGS: begin
                    nxt_core.rdata[`DBR_FLAG_CF]   = core_ff.flags.cf;
                    nxt_core.rdata[`DBR_FLAG_PF]   = core_ff.flags.pf;
                    nxt_core.rdata[`DBR_FLAG_AF]   = core_ff.flags.af;
                    nxt_core.rdata[`DBR_FLAG_ZF]   = core_ff.flags.zf;
                    nxt_core.rdata[`DBR_FLAG_SF]   = core_ff.flags.sf;
                    nxt_core.rdata[`DBR_FLAG_OF]   = core_ff.flags.of;
                    nxt_core.rdata[`DBR_FLAG_BUSY] = core_ff.state != DBR_IDLE;
                end
                `DBR_OFF_FAULT:    nxt_core.rdata = {30'h0, core_ff.last_fault};
                `DBR_OFF_IRQ_STAT: nxt_core.rdata = {28'h0, irq_stat};
                `DBR_OFF_IRQ_EN:   nxt_core.rdata = {28'h0, irq_en};
                default:           nxt_core.rdata = `DBR_RST_WORD;
            endcase
        end
    end

    // single register stage for all block state except the interrupt status and enable, which dbr_irq holds
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            core_ff.state      <= DBR_IDLE;
            core_ff.outcome    <= DBR_OK;
            core_ff.addr       <= `DBR_RST_QUAD;
            core_ff.long_mode  <= 1'b0;
            core_ff.leaf_err   <= `DBR_RST_WORD;
            core_ff.result     <= `DBR_RST_QUAD;
            core_ff.stage      <= `DBR_RST_QUAD;
            core_ff.flags      <= '0;
            core_ff.last_fault <= 2'b00;
            core_ff.rdata      <= `DBR_RST_WORD;
        end else begin
            core_ff <= nxt_core;
        end
    end

    // outputs; pulses come straight from the done state flop
    assign rdata_o      = core_ff.rdata;
    assign pm_req_o     = core_ff.state == DBR_WAIT;
    assign pm_addr_o    = core_ff.addr;
    assign done_o       = core_ff.state == DBR_DONE;
    assign gp_fault_o   = done_o && (core_ff.outcome == DBR_GP);
    assign pf_fault_o   = done_o && (core_ff.outcome == DBR_PF);
    assign fault_addr_o = core_ff.addr;

    // checks on the block's own behaviour
    default clocking dbr_cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    leaf_gate_a: assert property (
        (core_ff.state == DBR_IDLE) && start_req &&
        (core_ff.leaf_err != `DBR_LEAF_READ) |=> core_ff.state == DBR_IDLE
    ) else $error("start without read leaf was not ignored");

    align_long_a: assert property (
        (core_ff.state == DBR_IDLE) && start_req &&
        (core_ff.leaf_err == `DBR_LEAF_READ) && !seg_viol_i && !seg_unusable_i &&
        bus_i.wdata[`DBR_CTRL_LONG] && (core_ff.addr[2:0] != 3'h0)
        |=> gp_fault_o ##1 (core_ff.state == DBR_IDLE)
    ) else $error("long mode misalignment missed");

    align_short_a: assert property (
        (core_ff.state == DBR_IDLE) && start_req &&
        (core_ff.leaf_err == `DBR_LEAF_READ) && !seg_viol_i && !seg_unusable_i &&
        !bus_i.wdata[`DBR_CTRL_LONG] && (core_ff.addr[1:0] != 2'h0)
        |=> gp_fault_o
    ) else $error("short mode misalignment missed");

    epc_miss_a: assert property (
        pm_req_o && pm_ack_i && !pm_resp_i.in_epc
        |=> pf_fault_o && (fault_addr_o == $past(core_ff.addr))
    ) else $error("non protected address gave no page fault");

    entry_busy_a: assert property (
        pm_req_o && pm_ack_i && pm_resp_i.in_epc && pm_resp_i.conflict
        |=> gp_fault_o
    ) else $error("entry conflict gave no protection fault");

    not_debug_a: assert property (
        done_o && (core_ff.outcome == DBR_NDBG)
        |=> core_ff.flags.zf && (core_ff.leaf_err == `DBR_ERR_NOT_DEBUG) &&
            $stable(core_ff.result)
    ) else $error("not debuggable exit wrong");

    success_a: assert property (
        done_o && (core_ff.outcome == DBR_OK)
        |=> !core_ff.flags.zf && (core_ff.leaf_err == 32'h0000_0000)
    ) else $error("success exit wrong");

    flags_clear_a: assert property (
        done_o && (core_ff.outcome inside {DBR_OK, DBR_NDBG})
        |=> !(core_ff.flags.cf || core_ff.flags.pf || core_ff.flags.af ||
              core_ff.flags.of || core_ff.flags.sf)
    ) else $error("arithmetic flags not cleared");

    fault_quiet_a: assert property (
        gp_fault_o || pf_fault_o
        |=> $stable(core_ff.result) && $stable(core_ff.leaf_err) &&
            $stable(core_ff.flags)
    ) else $error("fault changed architectural state");
endmodule

// file: core/dbr_regs.svh
// offsets, field positions, reset values and codes of the debug read block
`ifndef DBR_REGS_SVH
`define DBR_REGS_SVH
// register byte offsets
`define DBR_OFF_LEAF      8'h00
`define DBR_OFF_ADDR_LO   8'h04
`define DBR_OFF_ADDR_HI   8'h08
`define DBR_OFF_CTRL      8'h0C
`define DBR_OFF_RES_LO    8'h10
`define DBR_OFF_RES_HI    8'h14
`define DBR_OFF_FLAGS     8'h18
`define DBR_OFF_FAULT     8'h1C
`define DBR_OFF_IRQ_STAT  8'h20
`define DBR_OFF_IRQ_CLR   8'h24
`define DBR_OFF_IRQ_EN    8'h28
// control fields
`define DBR_CTRL_LONG     0
`define DBR_CTRL_START    1
// flag field positions
`define DBR_FLAG_CF       0
`define DBR_FLAG_PF       2
`define DBR_FLAG_AF       4
`define DBR_FLAG_ZF       6
`define DBR_FLAG_SF       7
`define DBR_FLAG_OF       11
`define DBR_FLAG_BUSY     16
// fault and interrupt fields
`define DBR_FAULT_GP      0
`define DBR_FAULT_PF      1
`define DBR_EVT_OK        0
`define DBR_EVT_NDBG      1
`define DBR_EVT_GP        2
`define DBR_EVT_PF        3
// codes and limits
`define DBR_LEAF_READ     32'h0000_0004
`define DBR_ERR_NOT_DEBUG 32'h0000_0001
`define DBR_TCS_LIMIT     12'h0100
`define DBR_PT_ENCLAVE_CONTROL_STRUCTURE       8'h00
`define DBR_REGULAR_PAGE_TYPE        8'h01
`define DBR_THREAD_CONTROL_PAGE_TYPE        8'h02
`define DBR_VERSION_ARRAY_PAGE_TYPE         8'h03
`define DBR_SHADOW_STACK_FIRST_PAGE_TYPE   8'h04
`define DBR_SHADOW_STACK_REST_PAGE_TYPE    8'h05
// reset values
`define DBR_RST_WORD      32'h0000_0000
`define DBR_RST_QUAD      64'h0000_0000_0000_0000
`endif

// file: core/dbr_pkg.sv
// types shared by the debug enclave read block
package dbr_pkg;
    typedef enum logic [2:0] {
        DBR_IDLE = 3'b001,
        DBR_WAIT = 3'b010,
        DBR_DONE = 3'b100
    } dbr_state_t;
    typedef enum logic [3:0] {
        DBR_OK   = 4'b0001,
        DBR_NDBG = 4'b0010,
        DBR_GP   = 4'b0100,
        DBR_PF   = 4'b1000
    } dbr_out_t;
    typedef struct packed {
        logic       we;
        logic       re;
        logic [7:0] addr;
        logic [31:0] wdata;
    } dbr_bus_t;
    typedef struct packed {
        logic        in_epc;
        logic        conflict;
        logic        valid;
        logic        pending;
        logic        modified;
        logic [7:0]  ptype;
        logic        owner_debug;
        logic [63:0] data;
    } dbr_pm_resp_t;
    typedef struct packed {
        logic cf;
        logic pf;
        logic af;
        logic zf;
        logic sf;
        logic of;
    } dbr_flags_t;
endpackage

// file: core/dbr_irq.sv
// sticky event status, enable mask and level interrupt
`timescale 1ns/1ps
module dbr_irq
    import dbr_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    // events and software access
    input  wire logic [3:0] event_i,
    input  wire logic       clr_we_i,
    input  wire logic       en_we_i,
    input  wire logic [3:0] wdata_i,
    // state out
    output logic [3:0]      stat_o,
    output logic [3:0]      en_o,
    output logic            irq_o
);
    typedef struct packed {
        logic [3:0] stat;
        logic [3:0] en;
    } dbr_irq_st_t;
    dbr_irq_st_t irq_ff, nxt_irq;
    // a new event outranks a clear landing in the same cycle
    always_comb begin
        nxt_irq = irq_ff;
        if (clr_we_i) begin
            nxt_irq.stat = irq_ff.stat & ~wdata_i;
        end
        nxt_irq.stat = nxt_irq.stat | event_i;
        if (en_we_i) begin
            nxt_irq.en = wdata_i;
        end
    end
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            irq_ff <= '0;
        end else begin
            irq_ff <= nxt_irq;
        end
    end
    assign stat_o = irq_ff.stat;
    assign en_o   = irq_ff.en;
    assign irq_o  = |(irq_ff.stat & irq_ff.en);
endmodule

// file: core/dbr_fmt.sv
// shapes the word read from the page into the data result register
`timescale 1ns/1ps
module dbr_fmt
    import dbr_pkg::*;
(
    // selection
    input  wire logic        long_i,
    input  wire logic        reg_or_tcs_i,
    // data
    input  wire logic [63:0] mem_i,
    input  wire logic [63:0] prev_i,
    output logic [63:0]      result_o
);
    logic [63:0] slot_val;
    // version slots only reveal whether they are in use
    assign slot_val = mem_i & ~64'h0000_0000_0000_0007;
    always_comb begin
        if (reg_or_tcs_i) begin
            // short mode leaves the upper half untouched
            result_o = long_i ? mem_i : {prev_i[63:32], mem_i[31:0]};
        end else if (slot_val != 64'h0000_0000_0000_0000) begin
            result_o = long_i ? 64'hFFFF_FFFF_FFFF_FFFF
                              : {prev_i[63:32], 32'hFFFF_FFFF};
        end else begin
            result_o = long_i ? 64'h0000_0000_0000_0000
                              : {prev_i[63:32], 32'h0000_0000};
        end
    end
endmodule

// file: dv/dbr_pm_model.sv
// page map and protected page cache stand-in with a programmable answer delay
`timescale 1ns/1ps
module dbr_pm_model
    import dbr_pkg::*;
(
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         reset_i,
    // lookup from the block
    input  wire logic         req_i,
    output logic              ack_o,
    output dbr_pm_resp_t      resp_o,
    // answer set up by the bench
    input  wire logic [7:0]   delay_i,
    input  wire dbr_pm_resp_t cfg_i
);
    logic [7:0] cnt_ff;
    logic       answered_ff;

    // one answer per lookup, after delay_i waiting cycles
    always_ff @(posedge clk_i) begin
        if (reset_i || !req_i) begin
            cnt_ff      <= 8'h00;
            ack_o       <= 1'b0;
            answered_ff <= 1'b0;
        end else if (!answered_ff && cnt_ff == delay_i) begin
            ack_o       <= 1'b1;
            answered_ff <= 1'b1;
        end else begin
            ack_o  <= 1'b0;
            cnt_ff <= cnt_ff + 8'h01;
        end
    end

    // garbage outside the ack cycle, so a late sample never sees the answer
    assign resp_o = ack_o ? cfg_i : ~cfg_i;
endmodule

// file: dv/debug_enclave_read_tb.sv
// self-checking bench: debug read block against an integer model
`timescale 1ns/1ps
`include "dbr_regs.svh"
module debug_enclave_read_tb
    import dbr_pkg::*;
;
    logic         clk_i;
    logic         reset_i = 1'b1;
    dbr_bus_t     bus_r;
    logic [31:0]  rdata;
    logic         seg_viol;
    logic         seg_unus;
    logic         pm_req;
    logic         pm_ack;
    logic [63:0]  pm_addr;
    dbr_pm_resp_t pm_resp;
    dbr_pm_resp_t pm_cfg;
    logic [7:0]   pm_dly;
    logic         done;
    logic         gp;
    logic         pf;
    logic [63:0]  fault_addr;
    logic         irq;
    logic [63:0]  m_res;
    logic [31:0]  m_leaf;
    logic [31:0]  m_flags;
    logic [31:0]  m_fault;
    logic [3:0]   m_stat;
    logic [3:0]   m_en;
    logic         d_gp;
    logic         d_pf;
    logic [63:0]  d_fa;
    logic [63:0]  pg;
    logic [31:0]  r32;
    int           t;
    int           n_done;
    int           mismatches;
    int           num_checks;
    int           cycles;
    integer       seed = 32'ha82a_62de;
    localparam logic [5:0] GOOD = 6'b101001;

    dbr_top u_dbr_top (.clk_i(clk_i), .reset_i(reset_i), .bus_i(bus_r), .rdata_o(rdata),
        .seg_viol_i(seg_viol), .seg_unusable_i(seg_unus), .pm_req_o(pm_req),
        .pm_addr_o(pm_addr), .pm_ack_i(pm_ack), .pm_resp_i(pm_resp), .done_o(done),
        .gp_fault_o(gp), .pf_fault_o(pf), .fault_addr_o(fault_addr), .irq_o(irq));
    dbr_pm_model u_dbr_pm_model (.clk_i(clk_i), .reset_i(reset_i), .req_i(pm_req),
        .ack_o(pm_ack), .resp_o(pm_resp), .delay_i(pm_dly), .cfg_i(pm_cfg));

    // free-running 100 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // latch outcome pulses mid-cycle, where the one-cycle pulses are settled;
    // the cycle ceiling cuts a hang short
    always @(negedge clk_i) begin
        cycles <= cycles + 1;
        if (done === 1'b1) begin
            n_done <= n_done + 1;
            d_gp   <= gp;
            d_pf   <= pf;
            d_fa   <= fault_addr;
        end
        if (cycles == 20000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    function automatic logic [63:0] rnd64();
        return {$random(seed), $random(seed)};
    endfunction

    // strobes last one cycle; a gap cycle keeps drivers from double assignment
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        bus_r <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
        @(posedge clk_i);
        bus_r <= '0;
    endtask

    task automatic rchk(input logic [7:0] a, input string what, input logic [63:0] exp);
        logic [31:0] got;
        @(posedge clk_i);
        bus_r <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 32'h0000_0000};
        @(posedge clk_i);
        bus_r <= '0;
        // read data stand only until the next edge, so take them mid-cycle
        @(negedge clk_i);
        got = rdata;
        @(posedge clk_i);
        chk(what, exp, {32'h0000_0000, got});
    endtask

    // one leaf run: m = {long mode, segment violation, segment unusable}
    task automatic go(input logic [2:0] m, input logic [11:0] off, input logic [5:0] f,
                      input logic [7:0] ty, input logic [63:0] d, input logic [7:0] dly);
        int          n0;
        int          ev;
        logic        rt;
        logic [63:0] a;
        logic [63:0] v;
        a = pg | {52'h0, off};
        rt = ty == `DBR_REGULAR_PAGE_TYPE || ty == `DBR_THREAD_CONTROL_PAGE_TYPE;
        pm_cfg <= '{in_epc: f[5], conflict: f[4], valid: f[3], pending: f[2],
                    modified: f[1], ptype: ty, owner_debug: f[0], data: d};
        pm_dly <= dly;
        seg_viol <= m[1];
        seg_unus <= m[0];
        wr(`DBR_OFF_ADDR_LO, a[31:0]);
        wr(`DBR_OFF_ADDR_HI, a[63:32]);
        wr(`DBR_OFF_LEAF, `DBR_LEAF_READ);
        m_leaf = `DBR_LEAF_READ;
        n0 = n_done;
        wr(`DBR_OFF_CTRL, {30'h0, 1'b1, m[2]});
        if (dly > 8'd7) begin
            // flags of the previous leaf stay visible beside the busy bit
            rchk(`DBR_OFF_FLAGS, "busy flag", 64'h0001_0000 | m_flags);
            wr(`DBR_OFF_ADDR_LO, $random(seed));
        end
        for (int i = 0; i < 80 && n_done == n0; i++) @(posedge clk_i);
        chk("done count", n0 + 1, n_done);
        // first failing check decides the outcome
        if (m[1] || m[0]) ev = `DBR_EVT_GP;
        else if (m[2] ? a[2:0] != 3'h0 : a[1:0] != 2'h0) ev = `DBR_EVT_GP;
        else if (!f[5]) ev = `DBR_EVT_PF;
        else if (f[4]) ev = `DBR_EVT_GP;
        else if (!f[3]) ev = `DBR_EVT_PF;
        else if (ty == `DBR_PT_ENCLAVE_CONTROL_STRUCTURE || ty > `DBR_SHADOW_STACK_REST_PAGE_TYPE) ev = `DBR_EVT_PF;
        else if (f[2] || f[1]) ev = `DBR_EVT_NDBG;
        else if (ty == `DBR_THREAD_CONTROL_PAGE_TYPE && a[11:0] >= `DBR_TCS_LIMIT) ev = `DBR_EVT_GP;
        else if (rt && !f[0]) ev = `DBR_EVT_GP;
        else ev = `DBR_EVT_OK;
        m_stat[ev] = 1'b1;
        v = (d & 64'hFFFF_FFFF_FFFF_FFF8) != 64'h0 ? 64'hFFFF_FFFF_FFFF_FFFF : 64'h0;
        if (ev == `DBR_EVT_OK) begin
            v = rt ? d : v;
            if (m[2]) m_res = v;
            else m_res[31:0] = v[31:0];
            m_leaf = 32'h0000_0000;
            m_flags = 32'h0000_0000;
        end else if (ev == `DBR_EVT_NDBG) begin
            m_leaf = `DBR_ERR_NOT_DEBUG;
            m_flags = 32'h0000_0001 << `DBR_FLAG_ZF;
        end else begin
            m_fault = 32'h0000_0001 << (ev == `DBR_EVT_GP ? `DBR_FAULT_GP : `DBR_FAULT_PF);
        end
        chk("protection fault", ev == `DBR_EVT_GP, d_gp);
        chk("page fault", ev == `DBR_EVT_PF, d_pf);
        if (ev == `DBR_EVT_PF) chk("fault address", a, d_fa);
        chk("lookup address", a, pm_addr);
        rchk(`DBR_OFF_RES_LO, "result low", m_res[31:0]);
        rchk(`DBR_OFF_RES_HI, "result high", m_res[63:32]);
        rchk(`DBR_OFF_LEAF, "leaf register", m_leaf);
        rchk(`DBR_OFF_FLAGS, "flags", m_flags);
        rchk(`DBR_OFF_FAULT, "fault register", m_fault);
        rchk(`DBR_OFF_IRQ_STAT, "event status", m_stat);
        chk("interrupt", |(m_stat & m_en), irq);
    endtask

    // main sequence
    initial begin
        bus_r = '0;
        seg_viol = 1'b0;
        seg_unus = 1'b0;
        pm_cfg = '0;
        pm_dly = 8'h00;
        {m_res, m_leaf, m_flags, m_fault, m_stat, m_en} = '0;
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        pg = rnd64() & 64'hFFFF_FFFF_FFFF_F000;
        go(3'b100, 12'h008, GOOD, `DBR_REGULAR_PAGE_TYPE, rnd64(), 8'd0);
        go(3'b000, 12'h014, GOOD, `DBR_REGULAR_PAGE_TYPE, rnd64(), 8'd1);
        go(3'b100, 12'h00C, GOOD, `DBR_REGULAR_PAGE_TYPE, rnd64(), 8'd0);
        go(3'b000, 12'h00C, GOOD, `DBR_REGULAR_PAGE_TYPE, rnd64(), 8'd2);
        go(3'b000, 12'h00E, GOOD, `DBR_REGULAR_PAGE_TYPE, rnd64(), 8'd0);
        go(3'b110, 12'h010, GOOD, `DBR_REGULAR_PAGE_TYPE, rnd64(), 8'd0);
        go(3'b101, 12'h010, GOOD, `DBR_REGULAR_PAGE_TYPE, rnd64(), 8'd0);
        go(3'b100, 12'h018, 6'b001001, `DBR_REGULAR_PAGE_TYPE, rnd64(), 8'd0);
        go(3'b100, 12'h018, 6'b111001, `DBR_REGULAR_PAGE_TYPE, rnd64(), 8'd1);
        go(3'b100, 12'h018, 6'b100001, `DBR_REGULAR_PAGE_TYPE, rnd64(), 8'd0);
        go(3'b100, 12'h020, 6'b101101, `DBR_REGULAR_PAGE_TYPE, rnd64(), 8'd0);
        go(3'b000, 12'h024, GOOD, `DBR_THREAD_CONTROL_PAGE_TYPE, rnd64(), 8'd0);
        go(3'b000, 12'h028, 6'b101011, `DBR_THREAD_CONTROL_PAGE_TYPE, rnd64(), 8'd3);
        go(3'b100, 12'h0F8, GOOD, `DBR_THREAD_CONTROL_PAGE_TYPE, rnd64(), 8'd0);
        go(3'b000, 12'h100, GOOD, `DBR_THREAD_CONTROL_PAGE_TYPE, rnd64(), 8'd0);
        go(3'b100, 12'hFF8, GOOD, `DBR_THREAD_CONTROL_PAGE_TYPE, rnd64(), 8'd0);
        go(3'b100, 12'h030, 6'b101000, `DBR_REGULAR_PAGE_TYPE, rnd64(), 8'd0);
        go(3'b100, 12'h030, 6'b101000, `DBR_VERSION_ARRAY_PAGE_TYPE, 64'h8, 8'd0);
        go(3'b110, 12'h031, 6'b001001, `DBR_REGULAR_PAGE_TYPE, rnd64(), 8'd0);
        go(3'b100, 12'h038, 6'b011001, `DBR_REGULAR_PAGE_TYPE, rnd64(), 8'd0);
        go(3'b100, 12'h200, 6'b101100, `DBR_THREAD_CONTROL_PAGE_TYPE, rnd64(), 8'd0);
        go(3'b100, 12'h040, GOOD, `DBR_REGULAR_PAGE_TYPE, rnd64(), 8'd12);
        for (t = 0; t < 16; t++) begin
            go({t[0], 2'b00}, 12'h048, GOOD, {5'h0, t[3:1]},
               (t[0] ^ t[1]) ? rnd64() | 64'h8 : rnd64() & 64'h7, 8'd0);
        end
        // a start with the wrong leaf number must stay idle
        wr(`DBR_OFF_LEAF, 32'h0000_0005);
        m_leaf = 32'h0000_0005;
        t = n_done;
        wr(`DBR_OFF_CTRL, 32'h0000_0003);
        repeat (10) @(posedge clk_i);
        chk("done count", t, n_done);
        rchk(`DBR_OFF_LEAF, "leaf register", m_leaf);
        // read-only result and unmapped offset
        wr(`DBR_OFF_RES_LO, $random(seed));
        rchk(`DBR_OFF_RES_LO, "result low", m_res[31:0]);
        rchk(8'h3C, "unmapped", 64'h0);
        // interrupt enable, clear and masking
        m_en = 4'b1010;
        wr(`DBR_OFF_IRQ_EN, {28'h0, m_en});
        rchk(`DBR_OFF_IRQ_EN, "event enable", m_en);
        chk("interrupt", |(m_stat & m_en), irq);
        wr(`DBR_OFF_IRQ_CLR, 32'h0000_000F);
        m_stat = 4'h0;
        rchk(`DBR_OFF_IRQ_STAT, "event status", m_stat);
        chk("interrupt", 64'h0, irq);
        go(3'b100, 12'h018, 6'b100001, `DBR_REGULAR_PAGE_TYPE, rnd64(), 8'd0);
        go(3'b100, 12'h050, GOOD, `DBR_REGULAR_PAGE_TYPE, rnd64(), 8'd0);
        wr(`DBR_OFF_IRQ_CLR, 32'h0000_0008);
        m_stat[3] = 1'b0;
        rchk(`DBR_OFF_IRQ_STAT, "event status", m_stat);
        chk("interrupt", 64'h0, irq);
        // random mix of faults and page states
        for (t = 0; t < 24; t++) begin
            pg = rnd64() & 64'hFFFF_FFFF_FFFF_F000;
            r32 = $random(seed);
            go({r32[0], r32[9:8] == 2'b11, r32[11:10] == 2'b11},
               {r32[23:15], r32[2] & r32[1], 2'b00},
               {r32[14] | r32[30], r32[4], 1'b1, r32[5] & r32[6], r32[7] & r32[12], r32[13]},
               {5'h0, r32[27:25]}, rnd64(), {6'h0, r32[29:28]});
        end
        tally_and_finish();
    end
endmodule
